// [hw/srcc_pkg.sv]
package srcc_pkg;
  // ---------------------------------------------------------------------------
  // Bus register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD      = 8'h00;
  localparam logic [7:0] ADDR_CYC_TIME = 8'h04;
  localparam logic [7:0] ADDR_CYC_STAT = 8'h08;
  localparam logic [7:0] ADDR_DIP      = 8'h0c;
  localparam logic [7:0] ADDR_FREQ     = 8'h10;
  localparam logic [7:0] ADDR_MODE     = 8'h14;
  localparam logic [7:0] ADDR_NV       = 8'h18;

  // ---------------------------------------------------------------------------
  // Command codes, written to CMD[3:0]; argument in CMD[31:16]
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP        = 4'h0,
    CMD_CYCLE_SET  = 4'h1,
    CMD_CYCLE_RST  = 4'h2,
    CMD_CYCLE_TIME = 4'h3,
    CMD_STANDBY    = 4'h4,
    CMD_DIP_TIME   = 4'h5,
    CMD_DIP_START  = 4'h6,
    CMD_FREQ       = 4'h7,
    CMD_FREQ_DEF   = 4'h8,
    CMD_CLEAR      = 4'h9,
    CMD_GO_LOCAL   = 4'ha,
    CMD_GO_REMOTE  = 4'hb,
    CMD_LOCKOUT    = 4'hc,
    CMD_QUERY      = 4'hd
  } srcc_cmd_e;

  // ---------------------------------------------------------------------------
  // Field positions and limits
  // ---------------------------------------------------------------------------
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_ARG_LSB = 16;
  localparam int CMD_OPT_LSB = 4;
  localparam logic [15:0] CYC_MIN_S  = 16'h0001;
  localparam logic [15:0] CYC_MAX_S  = 16'h7fff;  // 32767 s
  localparam logic [15:0] DIP_MAX_MS = 16'h7530;  // 30000 ms
  localparam logic [1:0]  OPT_MANUAL = 2'h0;
  localparam logic [1:0]  OPT_FIRST  = 2'h1;
  localparam logic [1:0]  OPT_POWER  = 2'h2;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RST_TON   = 16'h0001;
  localparam logic [15:0] RST_TOFF  = 16'h0001;
  localparam logic [15:0] RST_DIP   = 16'h0000;
  localparam logic [15:0] RST_FREQ  = 16'h01f4;   // 50.0 Hz in 0.1 Hz steps
  localparam logic [1:0]  RST_OPT   = OPT_FIRST;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ      = 250_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int TICK_MS_CYC = CLK_HZ / 1000;  // Cycles per millisecond
endpackage : srcc_pkg

// [hw/srcc_top.sv]
`timescale 1ns/1ps
// Behaviour
// - In cycle mode output is on for Ton, off for Toff, repeating.
// - On and off times accepted only between 1 and 32767 seconds.
// - Cycle set command enters cycle mode and starts the on phase.
// - Cycle reset command leaves cycle mode.
// - Cycle query reports on time, off time, remaining time and mode.
// - Standby command also ends cycle mode.
// - Device clear restores initial settings and gives no reply.
// - Dip time in milliseconds, at most 30000 ms.
// - Dip start waits for the next reference sine zero crossing.
// - Output is off for the dip duration, then restored.
// - Dip query returns programmed dip duration in milliseconds.
// - Frequency command sets setpoint; query returns it.
// - Frequency default stores setpoint to nonvolatile; loaded at power-up.
// - Go-local selects front panel operation, no reply.
// - Going local also clears front panel lockout.
// - Go-remote enters remote, stores option permanently, no reply.
// - Option 0: remote only by explicit go-remote; queries still work.
// - Option 1: any command except go-local and nop enters remote.
// - Option 1 is the factory default.
// - Option 2: remote entered directly at power-up.
// - Option 2 blocks local mode and ignores front panel.
// - Auto-remote option is retained over a reboot.
module srcc_top
  import srcc_pkg::*;
#(
  parameter int TICK_CYC = TICK_MS_CYC  // Shorten for simulation
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        CLK_EN_I,
  // Wishbone classic slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             WB_ERR_O,
  // Reference sine and front panel
  input  wire logic        REF_ZERO_I,
  input  wire logic        PANEL_REQ_I,
  // Nonvolatile store, captured values presented at power-up
  input  wire logic [15:0] NV_FREQ_I,
  input  wire logic [1:0]  NV_OPT_I,
  input  wire logic        NV_VALID_I,
  output logic      [15:0] NV_FREQ_O,
  output logic      [1:0]  NV_OPT_O,
  output logic             NV_FREQ_WR_O,
  output logic             NV_OPT_WR_O,
  // Block outputs
  output logic             OUTPUT_ON_O,
  output logic      [15:0] FREQ_SET_O,
  output logic             REMOTE_O,
  output logic             PANEL_EN_O,
  output logic             REPLY_O
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic        req;
  logic        wr_cmd;
  logic [3:0]  op;
  logic [15:0] arg;
  logic [1:0]  opt;
  logic        cmd_v;
  logic        ack_q;

  assign req    = WB_CYC_I && WB_STB_I && !ack_q && !WB_ERR_O;
  assign wr_cmd = req && WB_WE_I && (WB_ADR_I == ADDR_CMD) && (&WB_SEL_I);
  assign op     = WB_DAT_I[CMD_OP_LSB +: 4];
  assign arg    = WB_DAT_I[CMD_ARG_LSB +: 16];
  assign opt    = WB_DAT_I[CMD_OPT_LSB +: 2];
  assign cmd_v  = wr_cmd && CLK_EN_I;

  function automatic logic is_op(input logic [3:0] o, input srcc_cmd_e c);
    is_op = (o == 4'(c));
  endfunction : is_op

  // ---------------------------------------------------------------------------
  // Power-up load state
  // ---------------------------------------------------------------------------
  logic boot_q;   // High until the first enabled edge after reset

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      boot_q <= 1'b1;
    end else if (CLK_EN_I) begin
      boot_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Prescaler: 1 ms tick and 1 s tick
  // ---------------------------------------------------------------------------
  logic [31:0] pre_q;
  logic [9:0]  ms_q;
  logic        tick_ms;
  logic        tick_s;

  assign tick_ms = CLK_EN_I && (pre_q == 32'(TICK_CYC - 1));
  assign tick_s  = tick_ms && (ms_q == 10'(MS_PER_S - 1));

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      pre_q <= '0;
      ms_q  <= '0;
    end else if (CLK_EN_I) begin
      pre_q <= tick_ms ? '0 : pre_q + 32'h1;
      if (tick_ms) begin
        ms_q <= tick_s ? '0 : ms_q + 10'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Cycle mode
  // ---------------------------------------------------------------------------
  logic [15:0] rest_q;
  logic        cyc_run_q;
  logic        cyc_on_q;
  logic        clear;

  assign clear = cmd_v && is_op(op, CMD_CLEAR);

  // The command word has room for one 16-bit argument only, so both times
  // are written together through their own register instead.
  logic        wr_ctime;
  logic [15:0] new_on;
  logic [15:0] new_off;

  assign new_on   = WB_DAT_I[15:0];
  assign new_off  = WB_DAT_I[31:16];
  assign wr_ctime = req && WB_WE_I && (WB_ADR_I == ADDR_CYC_TIME) && (&WB_SEL_I) && CLK_EN_I;

  logic [15:0] ton2_q;
  logic [15:0] toff2_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      ton2_q  <= RST_TON;
      toff2_q <= RST_TOFF;
    end else if (clear) begin
      ton2_q  <= RST_TON;
      toff2_q <= RST_TOFF;
    end else if (wr_ctime && in_range(new_on, CYC_MIN_S, CYC_MAX_S)
                 && in_range(new_off, CYC_MIN_S, CYC_MAX_S)) begin
      ton2_q  <= new_on;
      toff2_q <= new_off;
    end
  end

  // Cycle sequencer; a phase with time T ends on the T-th second tick after it starts
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      cyc_run_q <= 1'b0;
      cyc_on_q  <= 1'b0;
      rest_q    <= '0;
    end else if (CLK_EN_I) begin
      if (clear || (cmd_v && (is_op(op, CMD_CYCLE_RST) || is_op(op, CMD_STANDBY)))) begin
        cyc_run_q <= 1'b0;
        cyc_on_q  <= 1'b0;
        rest_q    <= '0;
      end else if (cmd_v && is_op(op, CMD_CYCLE_SET)) begin
        cyc_run_q <= 1'b1;
        cyc_on_q  <= 1'b1;
        rest_q    <= ton2_q;
      end else if (cyc_run_q && tick_s) begin
        if (rest_q <= 16'h1) begin
          cyc_on_q <= !cyc_on_q;
          rest_q   <= cyc_on_q ? toff2_q : ton2_q;
        end else begin
          rest_q <= rest_q - 16'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Dip
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DIP_IDLE = 2'b00,
    DIP_WAIT = 2'b01,
    DIP_OFF  = 2'b10
  } srcc_dip_e;

  srcc_dip_e   dip_st_q;
  logic [15:0] dip_ms_q;
  logic [15:0] dip_cnt_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      dip_ms_q <= RST_DIP;
    end else if (clear) begin
      dip_ms_q <= RST_DIP;
    end else if (cmd_v && is_op(op, CMD_DIP_TIME)
                 && in_range(arg, 16'h0, DIP_MAX_MS)) begin
      dip_ms_q <= arg;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      dip_st_q  <= DIP_IDLE;
      dip_cnt_q <= '0;
    end else if (CLK_EN_I) begin
      if (clear) begin
        dip_st_q <= DIP_IDLE;
      end else begin
        unique case (dip_st_q)
          DIP_IDLE: begin
            if (cmd_v && is_op(op, CMD_DIP_START) && dip_ms_q != 16'h0) begin
              dip_st_q <= DIP_WAIT;
            end
          end
          DIP_WAIT: begin
            if (REF_ZERO_I) begin
              dip_st_q  <= DIP_OFF;
              dip_cnt_q <= dip_ms_q;
            end
          end
          DIP_OFF: begin
            if (tick_ms) begin
              if (dip_cnt_q <= 16'h1) begin
                dip_st_q <= DIP_IDLE;
              end
              dip_cnt_q <= dip_cnt_q - 16'h1;
            end
          end
          default: dip_st_q <= DIP_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Frequency and nonvolatile store
  // ---------------------------------------------------------------------------
  logic [15:0] freq_q;
  logic [15:0] nvf_q;
  logic [1:0]  opt_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      freq_q <= RST_FREQ;
    end else if (CLK_EN_I) begin
      // Stored copy is loaded on this same edge, so take the store's pins directly
      if (boot_q) begin
        freq_q <= NV_VALID_I ? NV_FREQ_I : RST_FREQ;
      end else if (clear) begin
        freq_q <= nvf_q;
      end else if (cmd_v && is_op(op, CMD_FREQ) && arg != 16'h0) begin
        freq_q <= arg;
      end
    end
  end

  // Stored copies mirror the external store; loaded once after reset
  logic nv_loaded_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      nvf_q        <= RST_FREQ;
      opt_q        <= RST_OPT;
      nv_loaded_q  <= 1'b0;
      NV_FREQ_WR_O <= 1'b0;
      NV_OPT_WR_O  <= 1'b0;
    end else if (CLK_EN_I) begin
      NV_FREQ_WR_O <= 1'b0;
      NV_OPT_WR_O  <= 1'b0;
      if (!nv_loaded_q) begin
        nv_loaded_q <= 1'b1;
        if (NV_VALID_I) begin
          nvf_q <= NV_FREQ_I;
          opt_q <= (NV_OPT_I > OPT_POWER) ? RST_OPT : NV_OPT_I;
        end
      end else if (cmd_v && is_op(op, CMD_FREQ_DEF)) begin
        nvf_q        <= freq_q;
        NV_FREQ_WR_O <= 1'b1;
      end else if (cmd_v && is_op(op, CMD_GO_REMOTE) && opt <= OPT_POWER) begin
        opt_q       <= opt;
        NV_OPT_WR_O <= 1'b1;
      end
    end
  end

  assign NV_FREQ_O  = nvf_q;
  assign NV_OPT_O   = opt_q;
  assign FREQ_SET_O = freq_q;

  // ---------------------------------------------------------------------------
  // Local / remote state
  // ---------------------------------------------------------------------------
  logic remote_q;
  logic lock_q;
  logic go_local;

  assign go_local = cmd_v && is_op(op, CMD_GO_LOCAL);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      remote_q <= 1'b0;
      lock_q   <= 1'b0;
    end else if (CLK_EN_I) begin
      if (nv_loaded_q && boot_q == 1'b0 && opt_q == OPT_POWER) begin
        remote_q <= 1'b1;
        lock_q   <= lock_q && !go_local;
      end else if (go_local) begin
        remote_q <= 1'b0;
        lock_q   <= 1'b0;
      end else if (cmd_v && is_op(op, CMD_GO_REMOTE)) begin
        remote_q <= 1'b1;
      end else if (cmd_v && is_op(op, CMD_LOCKOUT)) begin
        lock_q   <= 1'b1;
        remote_q <= remote_q || (opt_q == OPT_FIRST);
      end else if (cmd_v && opt_q == OPT_FIRST && !is_op(op, CMD_NOP)) begin
        remote_q <= 1'b1;
      end else if (PANEL_REQ_I && !lock_q) begin
        remote_q <= 1'b0;
      end
    end
  end

  assign REMOTE_O   = remote_q;
  assign PANEL_EN_O = !remote_q && opt_q != OPT_POWER;
  // Dip only blanks an on phase; outside cycle mode the output stays off
  assign OUTPUT_ON_O = cyc_run_q && cyc_on_q && (dip_st_q != DIP_OFF);

  // ---------------------------------------------------------------------------
  // Bus answer; queries read data, the query command produces a reply flag
  // ---------------------------------------------------------------------------
  logic        unmapped;
  logic [31:0] rd;

  assign unmapped = (WB_ADR_I > ADDR_NV) || (WB_ADR_I[1:0] != 2'b00);

  always_comb begin
    unique case (WB_ADR_I)
      ADDR_CYC_TIME: rd = {toff2_q, ton2_q};
      ADDR_CYC_STAT: rd = {14'h0, cyc_on_q, cyc_run_q, rest_q};
      ADDR_DIP:      rd = {14'h0, dip_st_q, dip_ms_q};
      ADDR_FREQ:     rd = {16'h0, freq_q};
      ADDR_MODE:     rd = {28'h0, lock_q, remote_q, opt_q};
      ADDR_NV:       rd = {16'h0, nvf_q};
      default:       rd = 32'h0;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      ack_q    <= 1'b0;
      WB_ERR_O <= 1'b0;
      WB_DAT_O <= '0;
      REPLY_O  <= 1'b0;
    end else if (CLK_EN_I) begin
      ack_q    <= req && !unmapped;
      WB_ERR_O <= req && unmapped;
      WB_DAT_O <= (req && !WB_WE_I) ? rd : 32'h0;
      // Only the query command replies; clear and mode changes stay silent
      REPLY_O  <= cmd_v && is_op(op, CMD_QUERY);
    end
  end

  assign WB_ACK_O = ack_q;

endmodule : srcc_top

// [sim/srcc_chk_sva.sv]
`timescale 1ns/1ps
module srcc_chk
  import srcc_pkg::*;
(
  input wire logic        CORE_CLK_I,
  input wire logic        RESET_N_I,
  input wire logic        CLK_EN_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic        WB_ACK_O,
  input wire logic        WB_ERR_O,
  input wire logic [15:0] NV_FREQ_O,
  input wire logic [1:0]  NV_OPT_O,
  input wire logic        NV_FREQ_WR_O,
  input wire logic        NV_OPT_WR_O,
  input wire logic        OUTPUT_ON_O,
  input wire logic [15:0] FREQ_SET_O,
  input wire logic        REMOTE_O,
  input wire logic        PANEL_EN_O,
  input wire logic        REPLY_O
);
  // --------
  // Helpers
  // --------
  logic       req;
  logic       cmd_wr;
  logic [3:0] op;
  logic [3:0] op_q;
  // Only the taking edge counts, not the ack cycle
  assign req    = WB_CYC_I && WB_STB_I && CLK_EN_I && !WB_ACK_O && !WB_ERR_O;
  assign cmd_wr = req && WB_WE_I && WB_ADR_I == ADDR_CMD && WB_SEL_I == 4'hf;
  assign op     = WB_DAT_I[3:0];
  // Last command, so a reply can be traced to a query
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      op_q <= CMD_NOP;
    end else if (cmd_wr) begin
      op_q <= op;
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // --------
  // Assertions
  // --------
  AST_ACK_NEXT: assert property (req |=> (WB_ACK_O ^ WB_ERR_O))
    else $error("bus request not answered in one cycle");
  AST_ERR_UNMAPPED: assert property (req && WB_ADR_I > ADDR_NV |=> WB_ERR_O)
    else $error("unmapped access not refused");
  AST_REPLY_QUERY: assert property (REPLY_O |-> op_q == CMD_QUERY)
    else $error("reply without query");
  AST_NV_FREQ: assert property (NV_FREQ_WR_O |-> ##[0:1] NV_FREQ_O == FREQ_SET_O)
    else $error("stored frequency differs from setpoint");
  AST_NV_OPT_REMOTE: assert property (NV_OPT_WR_O |-> ##[0:2] REMOTE_O)
    else $error("go remote left device local");
  AST_OPT2_REMOTE: assert property ((NV_OPT_O == OPT_POWER)[*2] |-> REMOTE_O)
    else $error("option 2 without remote");
  AST_OPT2_PANEL: assert property ((NV_OPT_O == OPT_POWER)[*2] |-> !PANEL_EN_O)
    else $error("panel enabled under option 2");
  AST_GO_LOCAL: assert property (cmd_wr && op == CMD_GO_LOCAL && NV_OPT_O != OPT_POWER
    |-> ##[1:3] !REMOTE_O)
    else $error("go local kept remote");
  AST_AUTO_REMOTE: assert property (cmd_wr && NV_OPT_O == OPT_FIRST && op != CMD_GO_LOCAL
    && op != CMD_CLEAR && op != CMD_NOP |-> ##[1:3] REMOTE_O)
    else $error("command did not enter remote");
  AST_CYCLE_STOP: assert property (cmd_wr && (op == CMD_CYCLE_RST || op == CMD_STANDBY)
    |-> ##[1:3] !OUTPUT_ON_O)
    else $error("output on after cycle stop");
  COV_DIP: cover property (cmd_wr && op == CMD_DIP_START);
  COV_FALL: cover property ($fell(OUTPUT_ON_O));
  COV_OPT2: cover property (NV_OPT_O == OPT_POWER && REMOTE_O);
endmodule : srcc_chk

bind srcc_top srcc_chk srcc_chk_i (.CORE_CLK_I, .RESET_N_I, .CLK_EN_I, .WB_CYC_I, .WB_STB_I,
  .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_ACK_O, .WB_ERR_O, .NV_FREQ_O, .NV_OPT_O,
  .NV_FREQ_WR_O, .NV_OPT_WR_O, .OUTPUT_ON_O, .FREQ_SET_O, .REMOTE_O, .PANEL_EN_O, .REPLY_O);

// [sim/srcc_nv_model.sv]
`timescale 1ns/1ps
module srcc_nv_model
  import srcc_pkg::*;
#(
  parameter int REF_PERIOD = 40
) (
  input  wire logic        clk_i,
  input  wire logic [15:0] freq_i,
  input  wire logic [1:0]  opt_i,
  input  wire logic        freq_wr_i,
  input  wire logic        opt_wr_i,
  output logic      [15:0] freq_o = RST_FREQ,
  output logic      [1:0]  opt_o = RST_OPT,
  output logic             valid_o = 1'b0,
  output logic             zero_o = 1'b0
);
  int   ph = 0;
  logic fwr_q = 1'b0;
  logic owr_q = 1'b0;
  // Store survives the block's reset; capture a cycle late so data has settled
  always @(posedge clk_i) begin
    fwr_q <= freq_wr_i;
    owr_q <= opt_wr_i;
    if (fwr_q) freq_o <= freq_i;
    if (owr_q) opt_o <= opt_i;
    if (fwr_q || owr_q) valid_o <= 1'b1;
  end
  // Reference sine zero crossing, one cycle high, free running
  always @(posedge clk_i) begin
    ph <= (ph == REF_PERIOD - 1) ? 0 : ph + 1;
    zero_o <= (ph == REF_PERIOD - 1);
  end
endmodule : srcc_nv_model

// [sim/srcc_top_test.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module srcc_top_test
  import srcc_pkg::*;
;
  localparam int TICK = 10;
  localparam int SEC = 1000 * TICK;
  localparam int LIMIT = 90000;
  logic clk, rst_n = 1'b0, cyc = 0, stb = 0, we = 0, panel_req = 0;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0, dat_o, rd_q;
  logic        ack, err, err_q, ref_zero, nv_valid, nv_fwr, nv_owr;
  logic        out_on, remote, panel_en, reply;
  logic [15:0] nv_freq_i, nv_freq_o, freq_set;
  logic [1:0]  nv_opt_i, nv_opt_o;
  int failures = 0, total_checks = 0, cyc_cnt = 0, replies = 0, since_zero = 0, n;
  logic [15:0] dip_in[3] = '{16'h7531, DIP_MAX_MS, 16'h0003};
  logic [15:0] dip_ex[3] = '{RST_DIP, DIP_MAX_MS, 16'h0003};
  logic [31:0] ct_in[4] = '{32'h0, 32'h80000001, 32'h7fff7fff, 32'h00010001};
  logic [31:0] ct_ex[4] = '{32'h00010001, 32'h00010001, 32'h7fff7fff, 32'h00010001};

  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  srcc_top #(.TICK_CYC(TICK)) srcc_top_i (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .CLK_EN_I(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .WB_ERR_O(err),
    .REF_ZERO_I(ref_zero), .PANEL_REQ_I(panel_req), .NV_FREQ_I(nv_freq_i),
    .NV_OPT_I(nv_opt_i), .NV_VALID_I(nv_valid), .NV_FREQ_O(nv_freq_o), .NV_OPT_O(nv_opt_o),
    .NV_FREQ_WR_O(nv_fwr), .NV_OPT_WR_O(nv_owr), .OUTPUT_ON_O(out_on),
    .FREQ_SET_O(freq_set), .REMOTE_O(remote), .PANEL_EN_O(panel_en), .REPLY_O(reply));

  srcc_nv_model srcc_nv_model_i (.clk_i(clk), .freq_i(nv_freq_o), .opt_i(nv_opt_o),
    .freq_wr_i(nv_fwr), .opt_wr_i(nv_owr), .freq_o(nv_freq_i), .opt_o(nv_opt_i),
    .valid_o(nv_valid), .zero_o(ref_zero));

  // Monitors and hang guard; non-blocking so the main thread sees settled counts
  always @(posedge clk) begin
    cyc_cnt++;
    replies <= replies + int'(reply === 1'b1);
    since_zero <= (ref_zero === 1'b1) ? 0 : since_zero + 1;
    if (cyc_cnt == LIMIT) begin
      failures++;
      summarize();
    end
  end

  function automatic logic [31:0] cw(srcc_cmd_e op, logic [15:0] arg, logic [1:0] opt);
    return {arg, 10'h0, opt, op};
  endfunction : cw

  // Classic single cycle: hold until ack or err is sampled, then idle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    rd_q = dat_o;
    err_q = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : wb

  task automatic reboot();
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : reboot

  // Length of the current output level in cycles
  task automatic hold(output int len);
    logic v;
    v = out_on;
    len = 0;
    while (out_on === v) begin
      @(posedge clk);
      len++;
    end
  endtask : hold

  task automatic summarize();
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  initial begin
    reboot();
    `CHK(freq_set, RST_FREQ)
    `CHK(remote, 1'b0)
    wb(0, ADDR_MODE, 0);
    `CHK(rd_q[1:0], OPT_FIRST)
    wb(1, ADDR_CMD, cw(CMD_FREQ, 16'h0258, 0));
    `CHK(freq_set, 16'h0258)
    `CHK(remote, 1'b1)
    wb(0, ADDR_FREQ, 0);
    `CHK(rd_q[15:0], 16'h0258)
    wb(1, ADDR_CMD, cw(CMD_FREQ_DEF, 0, 0));
    `CHK(nv_freq_o, 16'h0258)
    // Limits: one past the top is refused and the old value stays
    for (int i = 0; i < 3; i++) begin
      wb(1, ADDR_CMD, cw(CMD_DIP_TIME, dip_in[i], 0));
      wb(0, ADDR_DIP, 0);
      `CHK(rd_q[15:0], dip_ex[i])
    end
    for (int i = 0; i < 4; i++) begin
      wb(1, ADDR_CYC_TIME, ct_in[i]);
      wb(0, ADDR_CYC_TIME, 0);
      `CHK(rd_q, ct_ex[i])
    end
    wb(0, 8'h1c, 0);
    `CHK(err_q, 1'b1)
    wb(1, ADDR_CMD, cw(CMD_LOCKOUT, 0, 0));
    wb(0, ADDR_MODE, 0);
    `CHK(rd_q[3], 1'b1)
    wb(1, ADDR_CMD, cw(CMD_GO_LOCAL, 0, 0));
    `CHK(remote, 1'b0)
    wb(0, ADDR_MODE, 0);
    `CHK(rd_q[3], 1'b0)
    wb(1, ADDR_CMD, cw(CMD_QUERY, 0, 0));
    `CHK(replies, 1)
    // Cycle mode, 1 s on and 1 s off; the first phase may be partial
    wb(1, ADDR_CMD, cw(CMD_CYCLE_SET, 0, 0));
    `CHK(out_on, 1'b1)
    wb(0, ADDR_CYC_STAT, 0);
    `CHK(rd_q[16], 1'b1)
    `CHK(rd_q[15:0] <= 16'h0001, 1'b1)
    hold(n);
    hold(n);
    `CHK(n >= SEC - 2 && n <= SEC + 2, 1'b1)
    hold(n);
    `CHK(n >= SEC - 2 && n <= SEC + 2, 1'b1)
    hold(n);
    // Dip of 3 ms early in an on phase
    wb(1, ADDR_CMD, cw(CMD_DIP_START, 0, 0));
    while (out_on === 1'b1) @(posedge clk);
    `CHK(since_zero <= 3, 1'b1)
    hold(n);
    `CHK(n >= 2 * TICK && n <= 3 * TICK + 1, 1'b1)
    wb(1, ADDR_CMD, cw(CMD_CYCLE_RST, 0, 0));
    `CHK(out_on, 1'b0)
    wb(1, ADDR_CMD, cw(CMD_CYCLE_SET, 0, 0));
    wb(1, ADDR_CMD, cw(CMD_STANDBY, 0, 0));
    wb(0, ADDR_CYC_STAT, 0);
    `CHK(rd_q[16], 1'b0)
    `CHK(out_on, 1'b0)
    wb(1, ADDR_CMD, cw(CMD_CLEAR, 0, 0));
    wb(0, ADDR_DIP, 0);
    `CHK(rd_q[15:0], RST_DIP)
    // Option 2 locks remote, also over a reboot
    wb(1, ADDR_CMD, cw(CMD_GO_REMOTE, 0, OPT_POWER));
    `CHK(nv_opt_o, OPT_POWER)
    panel_req <= 1'b1;
    wb(1, ADDR_CMD, cw(CMD_GO_LOCAL, 0, 0));
    `CHK(remote, 1'b1)
    `CHK(panel_en, 1'b0)
    reboot();
    `CHK(remote, 1'b1)
    `CHK(freq_set, 16'h0258)
    panel_req <= 1'b0;
    wb(1, ADDR_CMD, cw(CMD_GO_REMOTE, 0, OPT_MANUAL));
    `CHK(nv_opt_o, OPT_MANUAL)
    wb(1, ADDR_CMD, cw(CMD_GO_LOCAL, 0, 0));
    wb(1, ADDR_CMD, cw(CMD_FREQ, RST_FREQ, 0));
    `CHK(remote, 1'b0)
    wb(0, ADDR_FREQ, 0);
    `CHK(rd_q[15:0], RST_FREQ)
    `CHK(replies, 1)
    summarize();
  end
endmodule : srcc_top_test
